// *** pkg/cell_rx_pkg.sv ***
// shared constants and carrier types for the cell and nibble receive port
package cell_rx_pkg;
  // ----------------------------------------------------------------
  // sizes and encodings
  // ----------------------------------------------------------------
  localparam int unsigned CELL_OCTETS   = 53;
  localparam int unsigned OCTET_W       = 8;
  localparam int unsigned NIBBLE_W      = 4;
  localparam int unsigned PHY_COUNT     = 4;
  localparam int unsigned PHY_SEL_W     = 2;
  localparam int unsigned CNT_W         = 6;
  localparam logic [5:0]  LAST_OCTET    = 6'h34;
  localparam logic [5:0]  FIRST_OCTET   = 6'h00;
  localparam logic        MODE_CELL     = 1'b0;
  localparam logic        MODE_NIBBLE   = 1'b1;
  localparam logic [7:0]  DATA_RST      = 8'h00;
  localparam logic [3:0]  NIB_RST       = 4'h0;

  // one received octet with its cell framing marks
  typedef struct packed {
    logic [7:0] data;
    logic       sop;
    logic       eop;
    logic [1:0] phy;
  } cell_octet_t;

  // one received nibble
  typedef struct packed {
    logic [3:0] data;
  } nibble_t;
endpackage

// *** core/link_edge_sync.sv ***
// two-flop synchroniser with rising-edge detect for the link clock
module link_edge_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // async level in, synchronised level and rising-edge pulse out
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_pulse
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_out  = sync_r;
  assign rise_pulse = sync_r & ~prev_r;
endmodule

// *** core/cell_nibble_receive_port.sv ***
// receive port: delineates 53-octet cells or collects nibbles from a phy
// What this block does
// - octet bus bit 7 MSB, bit 0 LSB
// - every cell is exactly 53 octets
// - nibble data on lines 0 to 3
// - line 3 is nibble MSB
module cell_nibble_receive_port
  import cell_rx_pkg::*;
(
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // configuration
  input  wire logic                          mode_nibble,
  input  wire logic [cell_rx_pkg::PHY_SEL_W-1:0] phy_sel,
  input  wire logic                          rx_run,
  // link pins
  input  wire logic                          link_clk,
  input  wire logic [7:0]                    rx_data_pin,
  output logic [cell_rx_pkg::PHY_COUNT-1:0]  rx_enable_n,
  // user side
  output cell_rx_pkg::cell_octet_t           octet_out,
  output logic                               octet_valid,
  output cell_rx_pkg::nibble_t               nibble_out,
  output logic                               nibble_valid,
  output logic                               phy_busy
);
  import cell_rx_pkg::*;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic       clk_lvl;
  logic       clk_rise;
  logic [7:0] data_meta_r;
  logic [7:0] data_sync_r;

  link_edge_sync u_clk_sync (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .async_in   (link_clk),
    .level_out  (clk_lvl),
    .rise_pulse (clk_rise)
  );

  // data goes through two flops, matching the clock path delay
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_meta_r <= DATA_RST;
      data_sync_r <= DATA_RST;
    end else begin
      data_meta_r <= rx_data_pin;
      data_sync_r <= data_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // receive state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_CELL, ST_NIBBLE} state_t;
  state_t                state_r;
  logic [CNT_W-1:0]      cnt_r;
  logic [PHY_SEL_W-1:0]  phy_r;
  logic                  mode_r;

  // phy and mode are latched only between cells so a cell never splits
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cnt_r   <= FIRST_OCTET;
      phy_r   <= '0;
      mode_r  <= MODE_CELL;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cnt_r <= FIRST_OCTET;
          if (rx_run) begin
            phy_r   <= phy_sel;
            mode_r  <= mode_nibble;
            state_r <= (mode_nibble == MODE_NIBBLE) ? ST_NIBBLE : ST_CELL;
          end
        end
        ST_CELL: begin
          if (clk_rise) begin
            if (cnt_r == LAST_OCTET) begin
              cnt_r <= FIRST_OCTET;
              if (!rx_run || phy_sel != phy_r || mode_nibble != mode_r) begin
                state_r <= ST_IDLE;
              end
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end
        ST_NIBBLE: begin
          if (!rx_run || mode_nibble != MODE_NIBBLE) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // enable: one-hot, active low
  // ----------------------------------------------------------------
  // only in cell mode; idle cells keep the stream gapless so no
  // valid qualifier is needed from the phy
  always_comb begin
    rx_enable_n = '1;
    if (state_r == ST_CELL) begin
      rx_enable_n[phy_r] = 1'b0;
    end
  end
  assign phy_busy = (state_r != ST_IDLE);

  // ----------------------------------------------------------------
  // output capture
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      octet_out   <= '0;
      octet_valid <= 1'b0;
    end else begin
      octet_valid <= (state_r == ST_CELL) && clk_rise;
      if ((state_r == ST_CELL) && clk_rise) begin
        octet_out.data <= data_sync_r[7:0];
        octet_out.sop  <= (cnt_r == FIRST_OCTET);
        octet_out.eop  <= (cnt_r == LAST_OCTET);
        octet_out.phy  <= phy_r;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      nibble_out   <= '{data: NIB_RST};
      nibble_valid <= 1'b0;
    end else begin
      nibble_valid <= (state_r == ST_NIBBLE) && clk_rise;
      if ((state_r == ST_NIBBLE) && clk_rise) begin
        nibble_out.data <= data_sync_r[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_first;
    octet_valid && octet_out.sop;
  endsequence

  property p_onehot;
    @(posedge sys_clk) disable iff (sys_rst)
      $countones(~rx_enable_n) <= 1;
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one phy enabled");

  property p_no_en_nibble;
    @(posedge sys_clk) disable iff (sys_rst)
      (state_r == ST_NIBBLE) |-> (&rx_enable_n);
  endproperty
  a_no_en_nibble: assert property (p_no_en_nibble) else $error("enable in nibble mode");

  property p_sop_eop;
    @(posedge sys_clk) disable iff (sys_rst)
      (octet_valid && octet_out.eop) |-> (cnt_r == FIRST_OCTET);
  endproperty
  a_sop_eop: assert property (p_sop_eop) else $error("cell did not wrap at 53");

  property p_cnt_max;
    @(posedge sys_clk) disable iff (sys_rst)
      cnt_r <= LAST_OCTET;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("octet count past cell end");

  property p_octet_data;
    @(posedge sys_clk) disable iff (sys_rst)
      ((state_r == ST_CELL) && clk_rise) |=> (octet_out.data == $past(data_sync_r));
  endproperty
  a_octet_data: assert property (p_octet_data) else $error("octet bit order wrong");

  property p_nib_data;
    @(posedge sys_clk) disable iff (sys_rst)
      ((state_r == ST_NIBBLE) && clk_rise) |=>
        (nibble_out.data[3] == $past(data_sync_r[3]) && nibble_valid);
  endproperty
  a_nib_data: assert property (p_nib_data) else $error("nibble msb wrong");

  property p_sop_follows;
    @(posedge sys_clk) disable iff (sys_rst)
      (octet_valid && octet_out.eop && state_r == ST_CELL) |->
        ##[1:200] (octet_valid && octet_out.sop);
  endproperty
  a_sop_follows: assert property (p_sop_follows) else $error("no cell start after end");

  property p_en_stable;
    @(posedge sys_clk) disable iff (sys_rst)
      (s_first ##1 (state_r == ST_CELL)) |-> $stable(rx_enable_n) || (cnt_r == FIRST_OCTET);
  endproperty
  a_en_stable: assert property (p_en_stable) else $error("phy switched mid cell");
endmodule

// *** dv/phy_model.sv ***
// behavioural phy partner that streams back-to-back cells while enabled
module phy_model
  import cell_rx_pkg::*;
#(parameter logic [1:0] PHY_ID = 2'h0)
(
  // link side
  input  wire logic       link_clk,
  input  wire logic       enable_n,
  output logic [7:0]      data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] idx_r  = FIRST_OCTET;
  logic       seen_r = 1'b0;
  logic [7:0] last_r = DATA_RST;
  always @(posedge link_clk) begin
    seen_r <= !enable_n;
    if (!enable_n) last_r <= data_out;
  end
  // no gaps: the index wraps straight into the next cell
  always @(negedge link_clk) begin
    if (enable_n) idx_r <= FIRST_OCTET;
    else if (seen_r) idx_r <= (idx_r == LAST_OCTET) ? FIRST_OCTET : idx_r + 6'h01;
  end
  // released bus shows the inverse of the last octet, never a held value
  assign data_out = enable_n ? ~last_r : {PHY_ID, idx_r} ^ 8'h5a;
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the cell and nibble receive port
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cell_rx_pkg::*;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, link_clk = 1'b0;
  logic        mode_nibble = MODE_CELL, rx_run = 1'b0, cell_on = 1'b0;
  logic [1:0]  phy_sel = 2'h0, exp_phy = 2'h0;
  logic [3:0]  nib_r = NIB_RST, rx_enable_n;
  logic [5:0]  idx_r = FIRST_OCTET;
  logic [7:0]  rx_data_pin;
  logic [7:0]  phy_d [4];
  logic        octet_valid, nibble_valid, phy_busy;
  cell_octet_t octet_out;
  nibble_t     nibble_out;
  int          n_fail = 0, checked = 0, cells = 0, nibs = 0, cyc = 0;

  initial forever #2 sys_clk = ~sys_clk;
  // link clock free of any phase tie to the system clock
  initial begin
    #3.1;
    forever #62.5 link_clk = ~link_clk;
  end

  cell_nibble_receive_port cell_nibble_receive_port_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .mode_nibble(mode_nibble), .phy_sel(phy_sel),
    .rx_run(rx_run), .link_clk(link_clk), .rx_data_pin(rx_data_pin),
    .rx_enable_n(rx_enable_n), .octet_out(octet_out), .octet_valid(octet_valid),
    .nibble_out(nibble_out), .nibble_valid(nibble_valid), .phy_busy(phy_busy));

  for (genvar g = 0; g < 4; g++) begin : phy_g
    phy_model #(.PHY_ID(2'(g))) phy_model_i (
      .link_clk(link_clk), .enable_n(rx_enable_n[g]), .data_out(phy_d[g]));
  end

  // shared bus: the enabled phy wins; upper lines toggle in nibble mode
  always_comb begin
    rx_data_pin = mode_nibble ? {~nib_r, nib_r} : phy_d[0];
    for (int k = 0; k < 4; k++) if (!mode_nibble && !rx_enable_n[k]) rx_data_pin = phy_d[k];
  end

  function automatic logic [7:0] exp_octet(input logic [5:0] i, input logic [1:0] p);
    return {p, i} ^ 8'h5a;
  endfunction

  task automatic close_out;
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  always @(negedge link_clk) nib_r <= (nibs == 0) ? 4'h8 : 4'($urandom);
  // first cell keeps its phy so one back-to-back cell with no idle pass is exercised
  always @(posedge sys_clk) if (octet_valid && octet_out.sop)
    phy_sel <= (cells == 0) ? phy_sel : 2'($urandom);
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  always @(negedge sys_clk) if (!sys_rst) begin
    check("enable_overlap", 8'h00, {7'h0, $countones(~rx_enable_n) > 1});
    if (octet_valid && cell_on) begin
      check("octet_data", exp_octet(idx_r, exp_phy), octet_out.data);
      check("octet_marks", {6'h0, idx_r == FIRST_OCTET, idx_r == LAST_OCTET},
            {6'h0, octet_out.sop, octet_out.eop});
      check("octet_phy", {6'h0, exp_phy}, {6'h0, octet_out.phy});
      // a phy change at cell end passes through idle, so every enable is off there
      check("enable_n", {4'h0, (idx_r == LAST_OCTET && phy_sel != exp_phy) ? 4'hf
            : ~(4'h1 << exp_phy)}, {4'h0, rx_enable_n});
      idx_r = (idx_r == LAST_OCTET) ? FIRST_OCTET : idx_r + 6'h01;
      if (idx_r == FIRST_OCTET) begin
        cells++;
        exp_phy = phy_sel;
        if (cells == 3) cell_on = 1'b0;
      end
    end
    if (nibble_valid && mode_nibble) begin
      check("nibble", {4'h0, nib_r}, {4'h0, nibble_out.data});
      check("enable_n_nib", 8'h0f, {4'h0, rx_enable_n});
      nibs++;
    end
  end

  initial begin
    void'($urandom(32'hbca8));
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    check("enable_n_idle", 8'h0f, {4'h0, rx_enable_n});
    @(negedge link_clk);
    @(posedge sys_clk);
    rx_run <= 1'b1;
    cell_on = 1'b1;
    for (int i = 0; i < 8000 && cells < 3; i++) @(posedge sys_clk);
    rx_run <= 1'b0;
    check("cells", 8'h03, 8'(cells));
    for (int i = 0; i < 4000 && phy_busy !== 1'b0; i++) @(posedge sys_clk);
    check("phy_busy_idle", 8'h00, {7'h0, phy_busy});
    mode_nibble <= MODE_NIBBLE;
    @(negedge link_clk);
    @(posedge sys_clk);
    rx_run <= 1'b1;
    for (int i = 0; i < 3000 && nibs < 40; i++) @(posedge sys_clk);
    check("nibbles", 8'd40, 8'(nibs));
    check("phy_busy_nib", 8'h01, {7'h0, phy_busy});
    close_out();
  end
endmodule
